// [inc/mfil_pkg.sv]
// shared constants and carrier types of the motion and fifo interrupt logic
`default_nettype none
package mfil_pkg;
	// register byte addresses on the wishbone slave
	localparam logic [7:0] ADR_STAT_FEAT = 8'h00;
	localparam logic [7:0] ADR_STAT_FIFO = 8'h04;
	localparam logic [7:0] ADR_FIFO_CFG  = 8'h08;
	localparam logic [7:0] ADR_WTM_LOW   = 8'h0c;
	localparam logic [7:0] ADR_WTM_HIGH  = 8'h10;
	localparam logic [7:0] ADR_CMD       = 8'h14;
	localparam logic [7:0] ADR_PIN1_CTL  = 8'h18;
	localparam logic [7:0] ADR_PIN2_CTL  = 8'h1c;
	localparam logic [7:0] ADR_LATCH     = 8'h20;
	localparam logic [7:0] ADR_MAP1      = 8'h24;
	localparam logic [7:0] ADR_MAP2      = 8'h28;
	localparam logic [7:0] ADR_ANY_CFG   = 8'h2c;
	localparam logic [7:0] ADR_NO_CFG    = 8'h30;
	localparam logic [7:0] ADR_RATE_CFG  = 8'h34;
	localparam logic [7:0] ADR_LEVEL     = 8'h38;
	// command codes and overread answers
	localparam logic [7:0]  CMD_FLUSH     = 8'hb0;
	localparam logic [15:0] OVR_HEADERLESS = 16'h8000;
	localparam logic [15:0] OVR_HEADER     = 16'h0080;
	// interrupt source vector positions (status and map registers)
	localparam int SRC_ANY  = 0;
	localparam int SRC_NO   = 1;
	localparam int SRC_FULL = 2;
	localparam int SRC_WTM  = 3;
	localparam int SRC_DRDY = 4;
	// pin control fields
	localparam int PIN_EDGE   = 0;
	localparam int PIN_LVL    = 1;
	localparam int PIN_OD     = 2;
	localparam int PIN_OUT_EN = 3;
	localparam int PIN_IN_EN  = 4;
	// fifo config fields
	localparam int CFG_HDR     = 0;
	localparam int CFG_TAG1    = 1;
	localparam int CFG_TAG2    = 2;
	localparam int CFG_ACC_EN  = 3;
	localparam int CFG_AUX_LSB = 4;
	// motion config fields
	localparam int MOT_DUR_LSB = 16;
	localparam int MOT_EN_LSB  = 29;
	// reset values
	localparam logic [7:0]  RST_FIFO_CFG = 8'h09;
	localparam logic [4:0]  RST_PIN_CTL  = 5'h00;
	localparam logic [4:0]  RST_MAP      = 5'h00;
	localparam logic [7:0]  RST_WTM_LOW  = 8'h00;
	localparam logic [4:0]  RST_WTM_HIGH = 5'h02;
	localparam logic [31:0] RST_MOT_CFG  = 32'h0005_00aa;
	localparam logic [7:0]  RST_RATE_CFG = 8'h88;

	typedef struct packed {
		logic signed [15:0] x;
		logic signed [15:0] y;
		logic signed [15:0] z;
	} mfil_sample_s;

	typedef struct packed {
		logic       push;
		logic       acc;
		logic       aux;
		logic [1:0] tag;
	} mfil_frame_s;

	typedef struct packed {
		logic              ack;
		logic [31:0]       rdata;
		logic [7:0]        fifo_cfg;
		logic [7:0]        wtm_lo;
		logic [4:0]        wtm_hi;
		logic [4:0]        pin1_ctl;
		logic [4:0]        pin2_ctl;
		logic              latch;
		logic [4:0]        map1;
		logic [4:0]        map2;
		logic [31:0]       any_cfg;
		logic [31:0]       no_cfg;
		logic [7:0]        rate_cfg;
		logic [4:0]        stat;
		logic              drdy_prev;
		logic [2:0][15:0]  any_ref;
		logic [2:0][15:0]  no_prev;
		logic              no_prev_ok;
		logic [12:0]       any_cnt;
		logic [12:0]       no_cnt;
		logic [1:0]        sync1;
		logic [1:0]        sync2;
		logic [1:0]        in_prev;
		logic [1:0]        edge_seen;
		logic              pin1_o;
		logic              pin1_oe;
		logic              pin2_o;
		logic              pin2_oe;
		logic              flush;
		mfil_frame_s       frame;
		logic [15:0]       ovr_word;
		logic              ovr_valid;
	} mfil_state_s;
endpackage
`default_nettype wire

// [rtl/mfil_top.sv]
// motion detection, fifo level interrupts, pin logic and frame tagging of the sensor
//
// How it works
// - overread returns 0x8000 or 0x0080 by mode
// - slower-sensor frames also carry faster sensors
// - pin level sets frame external tag
// - full interrupt above two-frames-short threshold
// - watermark interrupt when level reaches watermark
// - fifo interrupts suppressed during fifo read
// - latched fifo flag clears on read below threshold
// - flush command resets the fifo
// - automatic reset only on three config changes
// - any-motion slope against stored reference per axis
// - any-motion after duration samples over threshold
// - reference reloaded only when any-motion triggers
// - any-motion status drops when slope falls
// - no-motion slope between consecutive samples
// - no-motion after duration samples all below
// - no-motion cleared when slope reaches threshold
// - per-pin enable, polarity, open-drain or push-pull
// - pin as input, edge or level, self-fed
// - latch select for fifo and drdy; features latched
// - latched status cleared by reading it
// - non-latched status follows its condition
// - sources reach pins only through map bits
`timescale 1ns/10ps
`default_nettype none
module mfil_top #(
	parameter int FIFO_BYTES = 1024
) (
	input  wire logic                  clk,
	input  wire logic                  sys_rst,
	input  wire logic                  wb_cyc,
	input  wire logic                  wb_stb,
	input  wire logic                  wb_we,
	input  wire logic [7:0]            wb_adr,
	input  wire logic [3:0]            wb_sel,
	input  wire logic [31:0]           wb_dat_w,
	output logic      [31:0]           wb_dat_r,
	output logic                       wb_ack,
	input  wire logic [13:0]           fifo_level,
	input  wire logic [4:0]            max_frame_bytes,
	input  wire logic                  fifo_rd_busy,
	input  wire logic                  fifo_rd_req,
	input  wire logic                  drdy_level,
	input  wire logic                  sample_tick,
	input  wire mfil_pkg::mfil_sample_s sample,
	input  wire logic                  acc_tick,
	input  wire logic                  aux_tick,
	input  wire logic                  cfg_transition,
	input  wire logic                  first_interrupt_pin_i,
	input  wire logic                  second_interrupt_pin_i,
	output logic                       first_interrupt_pin_o,
	output logic                       first_interrupt_pin_oe,
	output logic                       second_interrupt_pin_o,
	output logic                       second_interrupt_pin_oe,
	output logic                       fifo_flush,
	output mfil_pkg::mfil_frame_s      frame,
	output logic [15:0]                overread_word,
	output logic                       overread_valid
);
	localparam logic [13:0] FIFO_SIZE = 14'(FIFO_BYTES);

	mfil_pkg::mfil_state_s q;
	mfil_pkg::mfil_state_s d;

	// absolute difference of two signed samples, one bit wider so nothing wraps
	function automatic logic [16:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] t;
		t = {a[15], a} - {b[15], b};
		abs_diff = t[16] ? 17'(-t) : t;
	endfunction

	// byte-lane merge for wishbone writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		merge = r;
	endfunction

	logic        take;
	logic        wr;
	logic        rd;
	logic [31:0] wv;
	logic [31:0] mv;
	logic [13:0] full_thr;
	logic        full_cond;
	logic        wtm_cond;
	logic [4:0]  src;
	logic        first_interrupt_pin;
	logic        second_interrupt_pin;
	logic [1:0]  pin_in;
	logic [1:0]  tag_lvl;
	logic [2:0]  any_en;
	logic [2:0]  no_en;
	logic [15:0] any_thr;
	logic [15:0] no_thr;
	logic [12:0] any_dur;
	logic [12:0] no_dur;
	logic        any_cond;
	logic        no_cond;
	logic [2:0]  any_over;
	logic [2:0]  no_over;
	logic [15:0] cur [3];
	logic        any_trig;
	logic        no_trig;
	logic [4:0]  set_v;
	logic [4:0]  clr_v;
	logic [7:0]  new_cfg;
	logic        acc_in;
	logic        clr_feat;
	logic        clr_fifo;

	always_comb begin
		d = q;
		take = wb_cyc && wb_stb && !q.ack;
		wr = take && wb_we;
		rd = take && !wb_we;
		wv = 32'h0000_0000;
		new_cfg = q.fifo_cfg;
		set_v = 5'h00;
		clr_v = 5'h00;

		// bus answer one cycle after the request, dropped in the following cycle
		d.ack = take;
		d.rdata = 32'h0000_0000;
		d.flush = 1'b0;

		// read path; unmapped addresses answer with zero
		if (wb_adr == mfil_pkg::ADR_STAT_FEAT) begin
			wv = {30'h0, q.stat[mfil_pkg::SRC_NO], q.stat[mfil_pkg::SRC_ANY]};
		end else if (wb_adr == mfil_pkg::ADR_STAT_FIFO) begin
			wv = {29'h0, q.stat[4:2]};
		end else if (wb_adr == mfil_pkg::ADR_FIFO_CFG) begin
			wv = {24'h0, q.fifo_cfg};
		end else if (wb_adr == mfil_pkg::ADR_WTM_LOW) begin
			wv = {24'h0, q.wtm_lo};
		end else if (wb_adr == mfil_pkg::ADR_WTM_HIGH) begin
			wv = {27'h0, q.wtm_hi};
		end else if (wb_adr == mfil_pkg::ADR_PIN1_CTL) begin
			wv = {27'h0, q.pin1_ctl};
		end else if (wb_adr == mfil_pkg::ADR_PIN2_CTL) begin
			wv = {27'h0, q.pin2_ctl};
		end else if (wb_adr == mfil_pkg::ADR_LATCH) begin
			wv = {31'h0, q.latch};
		end else if (wb_adr == mfil_pkg::ADR_MAP1) begin
			wv = {27'h0, q.map1};
		end else if (wb_adr == mfil_pkg::ADR_MAP2) begin
			wv = {27'h0, q.map2};
		end else if (wb_adr == mfil_pkg::ADR_ANY_CFG) begin
			wv = q.any_cfg;
		end else if (wb_adr == mfil_pkg::ADR_NO_CFG) begin
			wv = q.no_cfg;
		end else if (wb_adr == mfil_pkg::ADR_RATE_CFG) begin
			wv = {24'h0, q.rate_cfg};
		end else if (wb_adr == mfil_pkg::ADR_LEVEL) begin
			wv = {18'h0, fifo_level};
		end
		if (rd) begin
			d.rdata = wv;
		end
		// the read word is the zero-extended register, so it serves as the old value of a byte merge
		mv = merge(wv, wb_dat_w, wb_sel);

		// write path; the command register is write-only
		if (wr) begin
			if (wb_adr == mfil_pkg::ADR_FIFO_CFG) begin
				new_cfg = mv[7:0];
			end else if (wb_adr == mfil_pkg::ADR_WTM_LOW) begin
				d.wtm_lo = mv[7:0];
			end else if (wb_adr == mfil_pkg::ADR_WTM_HIGH) begin
				d.wtm_hi = mv[4:0];
			end else if (wb_adr == mfil_pkg::ADR_CMD) begin
				if (wb_sel[0] && wb_dat_w[7:0] == mfil_pkg::CMD_FLUSH) begin
					d.flush = 1'b1;
				end
			end else if (wb_adr == mfil_pkg::ADR_PIN1_CTL) begin
				d.pin1_ctl = mv[4:0];
			end else if (wb_adr == mfil_pkg::ADR_PIN2_CTL) begin
				d.pin2_ctl = mv[4:0];
			end else if (wb_adr == mfil_pkg::ADR_LATCH) begin
				d.latch = mv[0];
			end else if (wb_adr == mfil_pkg::ADR_MAP1) begin
				d.map1 = mv[4:0];
			end else if (wb_adr == mfil_pkg::ADR_MAP2) begin
				d.map2 = mv[4:0];
			end else if (wb_adr == mfil_pkg::ADR_ANY_CFG) begin
				d.any_cfg = mv;
			end else if (wb_adr == mfil_pkg::ADR_NO_CFG) begin
				d.no_cfg = mv;
			end else if (wb_adr == mfil_pkg::ADR_RATE_CFG) begin
				d.rate_cfg = mv[7:0];
			end
		end
		d.fifo_cfg = new_cfg;

		// automatic fifo reset: only these three changes, nothing else
		if (new_cfg[mfil_pkg::CFG_HDR] != q.fifo_cfg[mfil_pkg::CFG_HDR]) begin
			d.flush = 1'b1;
		end
		if (!new_cfg[mfil_pkg::CFG_HDR] && !q.fifo_cfg[mfil_pkg::CFG_HDR]
				&& new_cfg[mfil_pkg::CFG_ACC_EN] != q.fifo_cfg[mfil_pkg::CFG_ACC_EN]) begin
			d.flush = 1'b1;
		end
		if (new_cfg[7:mfil_pkg::CFG_AUX_LSB] != q.fifo_cfg[7:mfil_pkg::CFG_AUX_LSB]) begin
			d.flush = 1'b1;
		end

		// fifo level conditions, gated while the host streams the data register
		full_thr = FIFO_SIZE - {8'h00, max_frame_bytes, 1'b0};
		full_cond = (fifo_level > full_thr) && !fifo_rd_busy;
		wtm_cond = (fifo_level >= {1'b0, q.wtm_hi, q.wtm_lo}) && !fifo_rd_busy;

		// overread answer depends on header mode
		d.ovr_valid = fifo_rd_req && fifo_level == 14'h0000;
		if (fifo_rd_req && fifo_level == 14'h0000) begin
			d.ovr_word = q.fifo_cfg[mfil_pkg::CFG_HDR] ? mfil_pkg::OVR_HEADER : mfil_pkg::OVR_HEADERLESS;
		end

		// motion configuration fields
		any_thr = q.any_cfg[15:0];
		no_thr = q.no_cfg[15:0];
		any_dur = q.any_cfg[28:mfil_pkg::MOT_DUR_LSB];
		no_dur = q.no_cfg[28:mfil_pkg::MOT_DUR_LSB];
		any_en = q.any_cfg[31:mfil_pkg::MOT_EN_LSB];
		no_en = q.no_cfg[31:mfil_pkg::MOT_EN_LSB];
		cur[0] = sample.x;
		cur[1] = sample.y;
		cur[2] = sample.z;

		// per-axis slopes: any-motion against the reference, no-motion against the last sample
		for (int i = 0; i < 3; i++) begin
			any_over[i] = any_en[i] && abs_diff(cur[i], q.any_ref[i]) > {1'b0, any_thr};
			no_over[i] = no_en[i] && abs_diff(cur[i], q.no_prev[i]) >= {1'b0, no_thr};
		end
		any_cond = |any_over;
		no_cond = (|no_en) && !(|no_over) && q.no_prev_ok;
		any_trig = 1'b0;
		no_trig = 1'b0;

		// duration counters; a duration of zero behaves as one sample
		if (sample_tick) begin
			if (any_cond) begin
				if (q.any_cnt + 13'h0001 >= any_dur) begin
					any_trig = 1'b1;
					d.any_cnt = 13'h0000;
					for (int i = 0; i < 3; i++) begin
						d.any_ref[i] = cur[i];
					end
				end else begin
					d.any_cnt = q.any_cnt + 13'h0001;
				end
			end else begin
				d.any_cnt = 13'h0000;
			end
			if (no_cond) begin
				if (q.no_cnt + 13'h0001 >= no_dur) begin
					no_trig = 1'b1;
				end else begin
					d.no_cnt = q.no_cnt + 13'h0001;
				end
			end else begin
				d.no_cnt = 13'h0000;
			end
			for (int i = 0; i < 3; i++) begin
				d.no_prev[i] = cur[i];
			end
			d.no_prev_ok = 1'b1;
		end

		// status: features always latched, fifo and drdy per latch select; set beats read clear
		clr_feat = rd && wb_adr == mfil_pkg::ADR_STAT_FEAT;
		clr_fifo = rd && wb_adr == mfil_pkg::ADR_STAT_FIFO;
		d.drdy_prev = drdy_level;
		set_v[mfil_pkg::SRC_ANY] = any_trig;
		set_v[mfil_pkg::SRC_NO] = no_trig;
		clr_v[mfil_pkg::SRC_ANY] = clr_feat || (sample_tick && !any_cond && (|any_en));
		clr_v[mfil_pkg::SRC_NO] = clr_feat || (sample_tick && !no_cond);
		if (q.latch) begin
			set_v[mfil_pkg::SRC_FULL] = full_cond;
			set_v[mfil_pkg::SRC_WTM] = wtm_cond;
			set_v[mfil_pkg::SRC_DRDY] = drdy_level && !q.drdy_prev;
			clr_v[mfil_pkg::SRC_FULL] = clr_fifo;
			clr_v[mfil_pkg::SRC_WTM] = clr_fifo;
			clr_v[mfil_pkg::SRC_DRDY] = clr_fifo;
			d.stat = (q.stat & ~clr_v) | set_v;
		end else begin
			d.stat[1:0] = (q.stat[1:0] & ~clr_v[1:0]) | set_v[1:0];
			d.stat[4:2] = {drdy_level, wtm_cond, full_cond};
		end

		// source routing to the two pins
		src = q.stat;
		first_interrupt_pin = |(src & q.map1);
		second_interrupt_pin = |(src & q.map2);

		// pin drivers: polarity, enable, open-drain pulls low only
		d.pin1_oe = q.pin1_ctl[mfil_pkg::PIN_OUT_EN]
			&& (!q.pin1_ctl[mfil_pkg::PIN_OD] || (first_interrupt_pin != q.pin1_ctl[mfil_pkg::PIN_LVL]));
		d.pin1_o = q.pin1_ctl[mfil_pkg::PIN_OD] ? 1'b0 : (first_interrupt_pin == q.pin1_ctl[mfil_pkg::PIN_LVL]);
		d.pin2_oe = q.pin2_ctl[mfil_pkg::PIN_OUT_EN]
			&& (!q.pin2_ctl[mfil_pkg::PIN_OD] || (second_interrupt_pin != q.pin2_ctl[mfil_pkg::PIN_LVL]));
		d.pin2_o = q.pin2_ctl[mfil_pkg::PIN_OD] ? 1'b0 : (second_interrupt_pin == q.pin2_ctl[mfil_pkg::PIN_LVL]);

		// pin inputs pass two flops; an output-enabled pin feeds its own interrupt back
		d.sync1 = {second_interrupt_pin_i, first_interrupt_pin_i};
		d.sync2 = q.sync1;
		pin_in[0] = q.pin1_ctl[mfil_pkg::PIN_OUT_EN] ? first_interrupt_pin : q.sync2[0];
		pin_in[1] = q.pin2_ctl[mfil_pkg::PIN_OUT_EN] ? second_interrupt_pin : q.sync2[1];
		pin_in[0] = pin_in[0] && q.pin1_ctl[mfil_pkg::PIN_IN_EN];
		pin_in[1] = pin_in[1] && q.pin2_ctl[mfil_pkg::PIN_IN_EN];
		d.in_prev = pin_in;

		// edge mode remembers a rising edge until the next frame takes it
		for (int i = 0; i < 2; i++) begin
			if (pin_in[i] && !q.in_prev[i]) begin
				d.edge_seen[i] = 1'b1;
			end else if (q.frame.push) begin
				d.edge_seen[i] = 1'b0;
			end
		end
		tag_lvl[0] = q.pin1_ctl[mfil_pkg::PIN_EDGE] ? q.edge_seen[0] : pin_in[0];
		tag_lvl[1] = q.pin2_ctl[mfil_pkg::PIN_EDGE] ? q.edge_seen[1] : pin_in[1];

		// frame composition on the common rate grid; faster sensors ride along with slower ones
		acc_in = acc_tick || (aux_tick && !cfg_transition && q.fifo_cfg[mfil_pkg::CFG_ACC_EN]
			&& q.rate_cfg[3:0] >= q.rate_cfg[7:4]);
		d.frame.push = acc_tick || aux_tick;
		d.frame.acc = acc_in && q.fifo_cfg[mfil_pkg::CFG_ACC_EN];
		d.frame.aux = aux_tick || (acc_tick && !cfg_transition && q.fifo_cfg[7:mfil_pkg::CFG_AUX_LSB] != 4'h0
			&& q.rate_cfg[7:4] >= q.rate_cfg[3:0]);
		d.frame.tag[0] = q.fifo_cfg[mfil_pkg::CFG_TAG1] && q.pin1_ctl[mfil_pkg::PIN_IN_EN] && tag_lvl[0];
		d.frame.tag[1] = q.fifo_cfg[mfil_pkg::CFG_TAG2] && q.pin2_ctl[mfil_pkg::PIN_IN_EN] && tag_lvl[1];
	end

	// one register bank for the whole block
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q <= '0;
			q.fifo_cfg <= mfil_pkg::RST_FIFO_CFG;
			q.wtm_lo <= mfil_pkg::RST_WTM_LOW;
			q.wtm_hi <= mfil_pkg::RST_WTM_HIGH;
			q.pin1_ctl <= mfil_pkg::RST_PIN_CTL;
			q.pin2_ctl <= mfil_pkg::RST_PIN_CTL;
			q.map1 <= mfil_pkg::RST_MAP;
			q.map2 <= mfil_pkg::RST_MAP;
			q.any_cfg <= mfil_pkg::RST_MOT_CFG;
			q.no_cfg <= mfil_pkg::RST_MOT_CFG;
			q.rate_cfg <= mfil_pkg::RST_RATE_CFG;
		end else begin
			q <= d;
		end
	end

	// every output straight from the state flops
	assign wb_dat_r = q.rdata;
	assign wb_ack = q.ack;
	assign first_interrupt_pin_o = q.pin1_o;
	assign first_interrupt_pin_oe = q.pin1_oe;
	assign second_interrupt_pin_o = q.pin2_o;
	assign second_interrupt_pin_oe = q.pin2_oe;
	assign fifo_flush = q.flush;
	assign frame = q.frame;
	assign overread_word = q.ovr_word;
	assign overread_valid = q.ovr_valid;
endmodule
`default_nettype wire

// [sim/mfil_assertions.sv]
// port checker for the motion and fifo interrupt logic, bound to the top module
`timescale 1ns/10ps
`default_nettype none
module mfil_assertions #(
	parameter int FIFO_BYTES = 1024
) (
	input wire logic                    clk,
	input wire logic                    sys_rst,
	input wire logic                    wb_cyc,
	input wire logic                    wb_stb,
	input wire logic                    wb_we,
	input wire logic [7:0]              wb_adr,
	input wire logic [3:0]              wb_sel,
	input wire logic [31:0]             wb_dat_w,
	input wire logic [31:0]             wb_dat_r,
	input wire logic                    wb_ack,
	input wire logic [13:0]             fifo_level,
	input wire logic                    fifo_rd_req,
	input wire logic                    acc_tick,
	input wire logic                    aux_tick,
	input wire logic                    fifo_flush,
	input wire mfil_pkg::mfil_frame_s   frame,
	input wire logic [15:0]             overread_word,
	input wire logic                    overread_valid
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	logic take;
	// a request is taken only while ack is low, so a held strobe is not taken twice
	assign take = wb_cyc & wb_stb & ~wb_ack;
	ack_follow_a: assert property (take |=> wb_ack) else $error("ack missing after request");
	ack_pulse_a: assert property (wb_ack |=> !wb_ack) else $error("ack longer than one cycle");
	rdata_idle_a: assert property (!wb_ack |-> wb_dat_r == 32'h0) else $error("read data not zero when idle");
	flush_cmd_a: assert property (take && wb_we && wb_adr == mfil_pkg::ADR_CMD && wb_sel[0]
		&& wb_dat_w[7:0] == mfil_pkg::CMD_FLUSH |=> fifo_flush) else $error("flush command without pulse");
	flush_pulse_a: assert property (fifo_flush |=> !fifo_flush) else $error("flush pulse too long");
	ovr_valid_a: assert property (fifo_rd_req && fifo_level == 14'h0 |=> overread_valid)
		else $error("overread not flagged");
	ovr_word_a: assert property (overread_valid |-> overread_word == mfil_pkg::OVR_HEADERLESS
		|| overread_word == mfil_pkg::OVR_HEADER) else $error("overread word wrong");
	frame_push_a: assert property ((acc_tick || aux_tick) |=> frame.push) else $error("frame not pushed");
	push_cause_a: assert property (frame.push |-> $past(acc_tick || aux_tick)) else $error("stray push");
endmodule
bind mfil_top mfil_assertions #(.FIFO_BYTES(FIFO_BYTES)) u_mfil_assertions (.clk(clk), .sys_rst(sys_rst),
	.wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
	.wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .fifo_level(fifo_level), .fifo_rd_req(fifo_rd_req),
	.acc_tick(acc_tick), .aux_tick(aux_tick), .fifo_flush(fifo_flush), .frame(frame),
	.overread_word(overread_word), .overread_valid(overread_valid));
`default_nettype wire

// [sim/mfil_host.sv]
// host processor model: a classic wishbone master for status and config access
`timescale 1ns/10ps
`default_nettype none
module mfil_host (
	input  wire logic        clk,
	input  wire logic        ack,
	input  wire logic [31:0] dat_r,
	output logic             cyc,
	output logic             stb,
	output logic             we,
	output logic [7:0]       adr,
	output logic [3:0]       sel,
	output logic [31:0]      dat_w
);
	initial {cyc, stb, we, adr, sel, dat_w} = '0;
	// one cycle; everything held until ack is sampled high, then cyc and stb released for at least a cycle
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		{cyc, stb, we, adr, sel, dat_w} <= {2'b11, w, a, 4'hf, d};
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		q = dat_r;
		{cyc, stb} <= 2'b00;
	endtask
endmodule
`default_nettype wire

// [sim/test_mfil_top.sv]
// self-checking bench of the motion and fifo interrupt logic
`timescale 1ns/10ps
`default_nettype none
module test_mfil_top;
	logic                   clk, sys_rst, cyc, stb, we, ack, busy, rdreq, stick, atick, pin1_i;
	logic                   flush, ovr_v, p1_o, p1_oe, drdy;
	logic [7:0]             adr;
	logic [3:0]             sel;
	logic [31:0]            dw, dr;
	logic [13:0]            lvl;
	logic [15:0]            ovr_w;
	logic [3:0]             ftag;
	mfil_pkg::mfil_sample_s smp;
	mfil_pkg::mfil_frame_s  frm;
	int                     miscompares, cmp_count, nfl, cycles, l, b, dy;
	int                     lv [4] = '{15, 16, 996, 997};
	mfil_top #(.FIFO_BYTES(1024)) u_mfil_top (.clk(clk), .sys_rst(sys_rst), .wb_cyc(cyc), .wb_stb(stb),
		.wb_we(we), .wb_adr(adr), .wb_sel(sel), .wb_dat_w(dw), .wb_dat_r(dr), .wb_ack(ack), .fifo_level(lvl),
		.max_frame_bytes(5'h0e), .fifo_rd_busy(busy), .fifo_rd_req(rdreq), .drdy_level(drdy),
		.sample_tick(stick), .sample(smp), .acc_tick(atick), .aux_tick(1'b0), .cfg_transition(1'b0),
		.first_interrupt_pin_i(pin1_i), .second_interrupt_pin_i(1'b0), .first_interrupt_pin_o(p1_o),
		.first_interrupt_pin_oe(p1_oe), .second_interrupt_pin_o(), .second_interrupt_pin_oe(),
		.fifo_flush(flush), .frame(frm), .overread_word(ovr_w), .overread_valid(ovr_v));
	mfil_host u_mfil_host (.clk(clk), .ack(ack), .dat_r(dr), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
		.sel(sel), .dat_w(dw));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// flush pulses are counted, tags of pushed frames kept; the ceiling cuts a hang short
	always @(posedge clk) begin
		cycles++;
		if (flush === 1'b1) nfl++;
		if (frm.push === 1'b1) ftag = {frm.acc, frm.aux, frm.tag};
		if (cycles > 6000) begin
			miscompares++;
			end_sim();
		end
	end
	task automatic end_sim;
		if (miscompares == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cy(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		u_mfil_host.xfer(1'b1, a, d, q);
	endtask
	task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		u_mfil_host.xfer(1'b0, a, 32'h0, q);
		chk(n, q, e);
	endtask
	// a write followed by the count of flush pulses it caused
	task automatic fl(input logic [7:0] a, input logic [31:0] d, input int e);
		int n0;
		n0 = nfl;
		wr(a, d);
		cy(2);
		chk("flush count", 32'(nfl - n0), 32'(e));
	endtask
	task automatic ovr(input logic [15:0] e);
		@(posedge clk) rdreq <= 1'b1;
		@(posedge clk) rdreq <= 1'b0;
		cy(2);
		chk("overread word", 32'(ovr_w), 32'(e));
	endtask
	task automatic samp(input logic [15:0] v);
		@(posedge clk);
		smp.x <= v;
		stick <= 1'b1;
		@(posedge clk) stick <= 1'b0;
		cy(2);
	endtask
	task automatic tagc(input logic [1:0] e);
		cy(4);
		@(posedge clk) atick <= 1'b1;
		@(posedge clk) atick <= 1'b0;
		cy(2);
		chk("frame tag", 32'(ftag[1:0]), 32'(e));
		chk("frame kinds", 32'(ftag[3:2]), 32'h1);
	endtask
	initial begin
		{sys_rst, lvl, busy, rdreq, stick, atick, pin1_i, drdy, smp} = {1'b1, 68'h0};
		void'($urandom(32'h44a5));
		cy(2);
		sys_rst <= 1'b0;
		rc("fifo cfg", mfil_pkg::ADR_FIFO_CFG, 32'(mfil_pkg::RST_FIFO_CFG));
		rc("wtm high", mfil_pkg::ADR_WTM_HIGH, 32'(mfil_pkg::RST_WTM_HIGH));
		rc("any cfg", mfil_pkg::ADR_ANY_CFG, mfil_pkg::RST_MOT_CFG);
		rc("rate cfg", mfil_pkg::ADR_RATE_CFG, 32'(mfil_pkg::RST_RATE_CFG));
		wr(8'h3c, 32'hffff_ffff);
		rc("unmapped", 8'h3c, 32'h0);
		fl(mfil_pkg::ADR_FIFO_CFG, 32'h09, 0);
		fl(mfil_pkg::ADR_FIFO_CFG, 32'h08, 1);
		fl(mfil_pkg::ADR_FIFO_CFG, 32'h00, 1);
		fl(mfil_pkg::ADR_FIFO_CFG, 32'h40, 1);
		fl(mfil_pkg::ADR_CMD, 32'hb0, 1);
		fl(mfil_pkg::ADR_CMD, 32'hb1, 0);
		ovr(mfil_pkg::OVR_HEADERLESS);
		fl(mfil_pkg::ADR_FIFO_CFG, 32'h41, 1);
		ovr(mfil_pkg::OVR_HEADER);
		wr(mfil_pkg::ADR_WTM_LOW, 32'h10);
		wr(mfil_pkg::ADR_WTM_HIGH, 32'h0);
		// boundary levels first, then random levels with random read-busy
		for (int i = 0; i < 12; i++) begin
			l = (i < 4) ? lv[i] : int'($urandom_range(1023, 0));
			b = (i < 4) ? 0 : int'($urandom_range(1, 0));
			dy = int'($urandom_range(1, 0));
			lvl <= 14'(l);
			busy <= b[0];
			drdy <= dy[0];
			cy(3);
			rc("fifo status", mfil_pkg::ADR_STAT_FIFO, {dy[0], ((b != 0) ? 2'b00 : {(l >= 16), (l > 996)})});
		end
		busy <= 1'b0;
		drdy <= 1'b0;
		lvl <= 14'd20;
		wr(mfil_pkg::ADR_LATCH, 32'h1);
		rc("latched", mfil_pkg::ADR_STAT_FIFO, 32'h2);
		rc("latched", mfil_pkg::ADR_STAT_FIFO, 32'h2);
		lvl <= 14'd5;
		cy(3);
		rc("latched", mfil_pkg::ADR_STAT_FIFO, 32'h2);
		rc("latched", mfil_pkg::ADR_STAT_FIFO, 32'h0);
		wr(mfil_pkg::ADR_LATCH, 32'h0);
		lvl <= 14'd20;
		wr(mfil_pkg::ADR_MAP1, 32'h8);
		wr(mfil_pkg::ADR_PIN1_CTL, 32'h0a);
		cy(3);
		chk("pin1", 32'({p1_oe, p1_o}), 32'h3);
		wr(mfil_pkg::ADR_PIN1_CTL, 32'h0c);
		cy(3);
		chk("pin1", 32'({p1_oe, p1_o}), 32'h2);
		lvl <= 14'd5;
		cy(3);
		chk("pin1", 32'({p1_oe, p1_o}), 32'h0);
		lvl <= 14'd20;
		wr(mfil_pkg::ADR_MAP1, 32'h0);
		cy(3);
		chk("pin1", 32'({p1_oe, p1_o}), 32'h0);
		wr(mfil_pkg::ADR_FIFO_CFG, 32'h43);
		wr(mfil_pkg::ADR_PIN1_CTL, 32'h10);
		pin1_i <= 1'b1;
		tagc(2'b01);
		wr(mfil_pkg::ADR_PIN1_CTL, 32'h0);
		tagc(2'b00);
		pin1_i <= 1'b0;
		wr(mfil_pkg::ADR_MAP1, 32'h8);
		wr(mfil_pkg::ADR_PIN1_CTL, 32'h1a);
		tagc(2'b01);
		// edge mode: one rising edge tags one frame only, the held level does not
		wr(mfil_pkg::ADR_PIN1_CTL, 32'h11);
		pin1_i <= 1'b1;
		tagc(2'b01);
		tagc(2'b00);
		// motion: x axis only, duration two samples, threshold 0x100
		wr(mfil_pkg::ADR_ANY_CFG, 32'h2002_0100);
		samp(16'h1000);
		samp(16'h1000);
		rc("any", mfil_pkg::ADR_STAT_FEAT, 32'h1);
		samp(16'h1000);
		rc("any", mfil_pkg::ADR_STAT_FEAT, 32'h0);
		samp(16'h0);
		rc("any", mfil_pkg::ADR_STAT_FEAT, 32'h0);
		samp(16'h0);
		rc("any", mfil_pkg::ADR_STAT_FEAT, 32'h1);
		wr(mfil_pkg::ADR_ANY_CFG, 32'h0);
		wr(mfil_pkg::ADR_NO_CFG, 32'h2002_0100);
		for (int i = 0; i < 4; i++) samp(16'h0);
		samp(16'h1000);
		rc("no", mfil_pkg::ADR_STAT_FEAT, 32'h0);
		samp(16'h1000);
		samp(16'h1000);
		rc("no", mfil_pkg::ADR_STAT_FEAT, 32'h2);
		end_sim();
	end
endmodule
`default_nettype wire
